/* rtl/cpurf_regs.svh */
// Register indices, flag bit positions, reset values and map bounds of the register set
`ifndef CPURF_REGS_SVH
`define CPURF_REGS_SVH
// Register indices on the plain software port
`define CPURF_IDX_DATA0 4'h0
`define CPURF_IDX_DATA1 4'h1
`define CPURF_IDX_DATA2 4'h2
`define CPURF_IDX_DATA3 4'h3
`define CPURF_IDX_PTR0 4'h4
`define CPURF_IDX_PTR1 4'h5
`define CPURF_IDX_FRAME 4'h6
`define CPURF_IDX_VTB 4'h7
`define CPURF_IDX_IP 4'h8
`define CPURF_IDX_TSP 4'h9
`define CPURF_IDX_HSP 4'hA
`define CPURF_IDX_SBP 4'hB
`define CPURF_IDX_STATE 4'hC
`define CPURF_IDX_ASP 4'hD
// State word bit positions
`define CPURF_BIT_C 0
`define CPURF_BIT_D 1
`define CPURF_BIT_Z 2
`define CPURF_BIT_S 3
`define CPURF_BIT_B 4
`define CPURF_BIT_O 5
`define CPURF_BIT_U 7
// Reset values
`define CPURF_RST_W16 16'h0000
`define CPURF_RST_W20 20'h0_0000
`define CPURF_RST_FLG 11'h000
// Address map bounds
`define CPURF_SFR_LO 20'h0_0000
`define CPURF_SFR_HI 20'h0_02FF
`define CPURF_RAM_LO 20'h0_0400
`define CPURF_DFL_LO 20'h0_2400
`define CPURF_DFL_HI 20'h0_2BFF
`define CPURF_ROM_TOP 20'h0_FFFF
`define CPURF_VEC_LO 20'h0_FFDC
`endif

/* rtl/cpurf_pkg.sv */
// Types shared by the register set and address decoder
`default_nettype none
package cpurf_pkg;
  typedef enum logic [2:0] {
    CPURF_RG_NONE = 3'h0,
    CPURF_RG_SFR = 3'h1,
    CPURF_RG_RAM = 3'h3,
    CPURF_RG_DFL = 3'h2,
    CPURF_RG_ROM = 3'h6,
    CPURF_RG_VEC = 3'h7
  } cpurf_region_e;

  typedef struct packed {
    logic [3:0][15:0] dat;
    logic [1:0][15:0] ptr;
    logic [15:0] frame;
    logic [19:0] vtb;
    logic [19:0] ip;
    logic [15:0] tsp;
    logic [15:0] hsp;
    logic [15:0] sbp;
    logic [10:0] cpu_state_word;
    logic [19:0] rdata;
  } cpurf_state_s;
endpackage : cpurf_pkg
`default_nettype wire

/* rtl/cpurf_top.sv */
// Programmer-visible register set and 1-Mbyte address decode of the core
//
// Implementation choices: the address-and-strobe port and the register offsets.
`include "cpurf_regs.svh"
`default_nettype none
module cpurf_top #(
  parameter logic [19:0] ROM_BYTES = 20'h0_4000,
  parameter logic [19:0] RAM_BYTES = 20'h0_0400,
  parameter logic HAS_DFL = 1'b1,
  parameter logic [767:0] SFR_USED = {768{1'b1}}
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Software register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [19:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [19:0] REG_RDATA,
  // Execution unit write-back
  input wire logic WB_EN,
  input wire logic [3:0] WB_IDX,
  input wire logic [1:0] WB_SIZE,
  input wire logic WB_HIGH,
  input wire logic [31:0] WB_DATA,
  // ALU flag update and instruction pointer load
  input wire logic FLAG_EN,
  input wire logic [1:0] FLAG_SIZE,
  input wire logic [31:0] ALU_RESULT,
  input wire logic ALU_CARRY,
  input wire logic ALU_OVF,
  input wire logic IP_LOAD,
  input wire logic [19:0] IP_NEXT,
  // Register read views
  output logic [15:0] DATA_WORD_ZERO,
  output logic [15:0] DATA_WORD_ONE,
  output logic [15:0] DATA_WORD_TWO,
  output logic [15:0] DATA_WORD_THREE,
  output logic [7:0] DATA_ZERO_HIGH_BYTE,
  output logic [7:0] DATA_ZERO_LOW_BYTE,
  output logic [31:0] LONG_DATA_PAIR_LOW,
  output logic [31:0] LONG_DATA_PAIR_HIGH,
  output logic [31:0] LONG_POINTER_PAIR,
  output logic [15:0] FRAME_POINTER,
  output logic [15:0] STATIC_BASE_POINTER,
  output logic [19:0] VECTOR_TABLE_BASE,
  output logic [19:0] INSTRUCTION_POINTER,
  output logic [15:0] ACTIVE_STACK_POINTER,
  output logic [10:0] CPU_STATE_WORD,
  output logic BANK_SEL,
  // Address decode
  input wire logic [19:0] MEM_ADDR,
  output logic [2:0] MEM_REGION,
  output logic MEM_RESERVED
);

  cpurf_pkg::cpurf_state_s st_r;
  cpurf_pkg::cpurf_state_s st_nxt;

  // Width-aware zero and sign test of a result
  function automatic logic [1:0] cpurf_zs(input logic [31:0] v, input logic [1:0] sz);
    logic [1:0] r;
    r = 2'b00;
    case (sz)
      2'd0: r = {v[7], v[7:0] == 8'h00};
      2'd1: r = {v[15], v[15:0] == 16'h0000};
      default: r = {v[31], v == 32'h0000_0000};
    endcase
    return r;
  endfunction : cpurf_zs

  // Stack slot index chosen by the stack-select bit
  function automatic logic [3:0] cpurf_sp_idx(input logic [10:0] f);
    return f[`CPURF_BIT_U] ? `CPURF_IDX_HSP : `CPURF_IDX_TSP;
  endfunction : cpurf_sp_idx

  // Write a word into one register slot; width trimmed per slot
  function automatic cpurf_pkg::cpurf_state_s cpurf_put(
    input cpurf_pkg::cpurf_state_s s, input logic [3:0] idx, input logic [19:0] d);
    cpurf_pkg::cpurf_state_s o;
    o = s;
    case (idx)
      `CPURF_IDX_DATA0: o.dat[0] = d[15:0];
      `CPURF_IDX_DATA1: o.dat[1] = d[15:0];
      `CPURF_IDX_DATA2: o.dat[2] = d[15:0];
      `CPURF_IDX_DATA3: o.dat[3] = d[15:0];
      `CPURF_IDX_PTR0: o.ptr[0] = d[15:0];
      `CPURF_IDX_PTR1: o.ptr[1] = d[15:0];
      `CPURF_IDX_FRAME: o.frame = d[15:0];
      `CPURF_IDX_VTB: o.vtb = d;
      `CPURF_IDX_IP: o.ip = d;
      `CPURF_IDX_TSP: o.tsp = d[15:0];
      `CPURF_IDX_HSP: o.hsp = d[15:0];
      `CPURF_IDX_SBP: o.sbp = d[15:0];
      `CPURF_IDX_STATE: o.cpu_state_word = d[10:0];
      // Alias resolved here, not by recursion, so every tool can flatten it
      `CPURF_IDX_ASP: begin
        if (cpurf_sp_idx(s.cpu_state_word) == `CPURF_IDX_HSP) begin
          o.hsp = d[15:0];
        end else begin
          o.tsp = d[15:0];
        end
      end
      default: o = s;
    endcase
    return o;
  endfunction : cpurf_put

  // Read a register slot, upper bits zero
  function automatic logic [19:0] cpurf_get(
    input cpurf_pkg::cpurf_state_s s, input logic [3:0] idx);
    logic [19:0] r;
    r = 20'h0_0000;
    case (idx)
      `CPURF_IDX_DATA0: r = {4'h0, s.dat[0]};
      `CPURF_IDX_DATA1: r = {4'h0, s.dat[1]};
      `CPURF_IDX_DATA2: r = {4'h0, s.dat[2]};
      `CPURF_IDX_DATA3: r = {4'h0, s.dat[3]};
      `CPURF_IDX_PTR0: r = {4'h0, s.ptr[0]};
      `CPURF_IDX_PTR1: r = {4'h0, s.ptr[1]};
      `CPURF_IDX_FRAME: r = {4'h0, s.frame};
      `CPURF_IDX_VTB: r = s.vtb;
      `CPURF_IDX_IP: r = s.ip;
      `CPURF_IDX_TSP: r = {4'h0, s.tsp};
      `CPURF_IDX_HSP: r = {4'h0, s.hsp};
      `CPURF_IDX_SBP: r = {4'h0, s.sbp};
      `CPURF_IDX_STATE: r = {9'h000, s.cpu_state_word};
      `CPURF_IDX_ASP: r = {4'h0, s.cpu_state_word[`CPURF_BIT_U] ? s.hsp : s.tsp};
      default: r = 20'h0_0000;
    endcase
    return r;
  endfunction : cpurf_get

  // Next-state logic: software port first, then core write-back, then flags
  always_comb begin
    logic [1:0] zs;
    logic [15:0] w;
    zs = 2'b00;
    w = 16'h0000;
    st_nxt = st_r;
    st_nxt.rdata = cpurf_get(st_r, REG_ADDR);
    if (REG_WR) begin
      st_nxt = cpurf_put(st_nxt, REG_ADDR, REG_WDATA);
    end
    // Core write-back wins over software in the same cycle
    if (WB_EN) begin
      case (WB_SIZE)
        2'd0: begin
          // Byte halves only exist on the first two data words
          if (WB_IDX == `CPURF_IDX_DATA0 || WB_IDX == `CPURF_IDX_DATA1) begin
            w = st_nxt.dat[WB_IDX[0]];
            if (WB_HIGH) begin
              w[15:8] = WB_DATA[7:0];
            end else begin
              w[7:0] = WB_DATA[7:0];
            end
            st_nxt.dat[WB_IDX[0]] = w;
          end
        end
        2'd2: begin
          // Long pairs: low word in the lower register
          if (WB_IDX == `CPURF_IDX_DATA0 || WB_IDX == `CPURF_IDX_DATA1) begin
            st_nxt.dat[WB_IDX[0]] = WB_DATA[15:0];
            st_nxt.dat[{1'b1, WB_IDX[0]}] = WB_DATA[31:16];
          end else if (WB_IDX == `CPURF_IDX_PTR0) begin
            st_nxt.ptr[0] = WB_DATA[15:0];
            st_nxt.ptr[1] = WB_DATA[31:16];
          end
        end
        default: begin
          st_nxt = cpurf_put(st_nxt, WB_IDX, WB_DATA[19:0]);
        end
      endcase
    end
    // Condition bits from the arithmetic unit
    if (FLAG_EN) begin
      zs = cpurf_zs(ALU_RESULT, FLAG_SIZE);
      st_nxt.cpu_state_word[`CPURF_BIT_C] = ALU_CARRY;
      st_nxt.cpu_state_word[`CPURF_BIT_Z] = zs[0];
      st_nxt.cpu_state_word[`CPURF_BIT_S] = zs[1];
      st_nxt.cpu_state_word[`CPURF_BIT_O] = ALU_OVF;
    end
    if (IP_LOAD) begin
      st_nxt.ip = IP_NEXT;
    end
    // Debug bit held at zero regardless of what is written
    st_nxt.cpu_state_word[`CPURF_BIT_D] = 1'b0;
    if (SRST) begin
      st_nxt.dat = {4{`CPURF_RST_W16}};
      st_nxt.ptr = {2{`CPURF_RST_W16}};
      st_nxt.frame = `CPURF_RST_W16;
      st_nxt.vtb = `CPURF_RST_W20;
      st_nxt.ip = `CPURF_RST_W20;
      st_nxt.tsp = `CPURF_RST_W16;
      st_nxt.hsp = `CPURF_RST_W16;
      st_nxt.sbp = `CPURF_RST_W16;
      st_nxt.cpu_state_word = `CPURF_RST_FLG;
      st_nxt.rdata = `CPURF_RST_W20;
    end
  end

  // Single state register, no feedback paths around it
  always_ff @(posedge CORE_CLK) begin
    st_r <= st_nxt;
  end

  // Register views
  assign REG_RDATA = st_r.rdata;
  assign DATA_WORD_ZERO = st_r.dat[0];
  assign DATA_WORD_ONE = st_r.dat[1];
  assign DATA_WORD_TWO = st_r.dat[2];
  assign DATA_WORD_THREE = st_r.dat[3];
  assign DATA_ZERO_HIGH_BYTE = st_r.dat[0][15:8];
  assign DATA_ZERO_LOW_BYTE = st_r.dat[0][7:0];
  assign LONG_DATA_PAIR_LOW = {st_r.dat[2], st_r.dat[0]};
  assign LONG_DATA_PAIR_HIGH = {st_r.dat[3], st_r.dat[1]};
  assign LONG_POINTER_PAIR = {st_r.ptr[1], st_r.ptr[0]};
  assign FRAME_POINTER = st_r.frame;
  assign STATIC_BASE_POINTER = st_r.sbp;
  assign VECTOR_TABLE_BASE = st_r.vtb;
  assign INSTRUCTION_POINTER = st_r.ip;
  assign ACTIVE_STACK_POINTER = st_r.cpu_state_word[`CPURF_BIT_U] ? st_r.hsp : st_r.tsp;
  assign CPU_STATE_WORD = st_r.cpu_state_word;
  assign BANK_SEL = st_r.cpu_state_word[`CPURF_BIT_B];

  // Address decode; vector table checked before ROM since it sits inside it
  logic [19:0] rom_lo;
  logic [19:0] ram_hi;
  assign rom_lo = `CPURF_ROM_TOP - ROM_BYTES + 20'h0_0001;
  assign ram_hi = `CPURF_RAM_LO + RAM_BYTES - 20'h0_0001;
  always_comb begin
    MEM_REGION = cpurf_pkg::CPURF_RG_NONE;
    MEM_RESERVED = 1'b0;
    if (MEM_ADDR >= `CPURF_VEC_LO && MEM_ADDR <= `CPURF_ROM_TOP) begin
      MEM_REGION = cpurf_pkg::CPURF_RG_VEC;
    end else if (MEM_ADDR >= rom_lo && MEM_ADDR <= `CPURF_ROM_TOP) begin
      MEM_REGION = cpurf_pkg::CPURF_RG_ROM;
    end else if (MEM_ADDR <= `CPURF_SFR_HI) begin
      MEM_REGION = cpurf_pkg::CPURF_RG_SFR;
      MEM_RESERVED = ~SFR_USED[MEM_ADDR[9:0]];
    end else if (MEM_ADDR >= `CPURF_RAM_LO && MEM_ADDR <= ram_hi) begin
      MEM_REGION = cpurf_pkg::CPURF_RG_RAM;
    end else if (HAS_DFL && MEM_ADDR >= `CPURF_DFL_LO && MEM_ADDR <= `CPURF_DFL_HI) begin
      MEM_REGION = cpurf_pkg::CPURF_RG_DFL;
    end
  end

endmodule : cpurf_top
`default_nettype wire

/* verif/cpurf_core_model.sv */
// Execution unit model: write-back, flag and jump pulses
`default_nettype none
module cpurf_core_model (
  input wire logic clk,
  output logic wb_en,
  output logic [3:0] wb_idx,
  output logic [1:0] wb_size,
  output logic wb_high,
  output logic [31:0] wb_data,
  output logic fl_en,
  output logic [1:0] fl_size,
  output logic [31:0] res,
  output logic cy,
  output logic ov,
  output logic ip_ld,
  output logic [19:0] ip_nx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wb_en, wb_idx, wb_size, wb_high, wb_data, fl_en, fl_size, res, cy, ov, ip_ld, ip_nx} = '0;
  // One-cycle pulses; data turns over on release so stale values never match
  task automatic wb(input logic [3:0] i, input logic [1:0] s, input logic h, input logic [31:0] d);
    @(posedge clk);
    {wb_en, wb_idx, wb_size, wb_high, wb_data} <= {1'b1, i, s, h, d};
    @(posedge clk);
    {wb_en, wb_data} <= {1'b0, ~d};
  endtask : wb
  // Flag pulses never carry the debug bit
  task automatic alu(input logic [1:0] s, input logic [31:0] r, input logic c, input logic o);
    @(posedge clk);
    {fl_en, fl_size, res, cy, ov} <= {1'b1, s, r, c, o};
    @(posedge clk);
    {fl_en, res} <= {1'b0, ~r};
  endtask : alu
  task automatic jump(input logic [19:0] a);
    @(posedge clk);
    {ip_ld, ip_nx} <= {1'b1, a};
    @(posedge clk);
    {ip_ld, ip_nx} <= {1'b0, ~a};
  endtask : jump
endmodule : cpurf_core_model
`default_nettype wire

/* verif/cpurf_top_asserts.sv */
// Concurrent checks on register set and decoder ports
`default_nettype none
module cpurf_top_asserts #(
  parameter logic [19:0] RAM_BYTES = 20'h0_0400
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [19:0] REG_RDATA,
  input wire logic IP_LOAD,
  input wire logic [19:0] IP_NEXT,
  input wire logic FLAG_EN,
  input wire logic [1:0] FLAG_SIZE,
  input wire logic [31:0] ALU_RESULT,
  input wire logic ALU_CARRY,
  input wire logic ALU_OVF,
  input wire logic [15:0] DATA_WORD_ZERO,
  input wire logic [15:0] DATA_WORD_TWO,
  input wire logic [7:0] DATA_ZERO_HIGH_BYTE,
  input wire logic [7:0] DATA_ZERO_LOW_BYTE,
  input wire logic [31:0] LONG_DATA_PAIR_LOW,
  input wire logic [19:0] INSTRUCTION_POINTER,
  input wire logic [15:0] ACTIVE_STACK_POINTER,
  input wire logic [10:0] CPU_STATE_WORD,
  input wire logic [19:0] MEM_ADDR,
  input wire logic [2:0] MEM_REGION
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // Read of the stack alias, answered one cycle later
  sequence s_asp_rd;
    REG_RD && REG_ADDR == 4'hD;
  endsequence
  a_byte_split: assert property ({DATA_ZERO_HIGH_BYTE, DATA_ZERO_LOW_BYTE} == DATA_WORD_ZERO)
    else $error("byte halves differ from word");
  a_pair_low: assert property (LONG_DATA_PAIR_LOW == {DATA_WORD_TWO, DATA_WORD_ZERO})
    else $error("long pair differs from words");
  a_asp_read: assert property (s_asp_rd |=> REG_RDATA == {4'h0, $past(ACTIVE_STACK_POINTER)})
    else $error("stack alias read wrong");
  a_ip_load: assert property (IP_LOAD |=> INSTRUCTION_POINTER == $past(IP_NEXT))
    else $error("instruction pointer not loaded");
  a_carry_flag: assert property (FLAG_EN |=> CPU_STATE_WORD[0] == $past(ALU_CARRY))
    else $error("carry bit wrong");
  a_zero_long: assert property (FLAG_EN && FLAG_SIZE == 2'h2 |=>
    CPU_STATE_WORD[2] == ($past(ALU_RESULT) == 32'h0000_0000)) else $error("zero bit wrong");
  a_sign_byte: assert property (FLAG_EN && FLAG_SIZE == 2'h0 |=>
    CPU_STATE_WORD[3] == $past(ALU_RESULT[7])) else $error("sign bit wrong");
  a_ovf_flag: assert property (FLAG_EN |=> CPU_STATE_WORD[5] == $past(ALU_OVF))
    else $error("overflow bit wrong");
  a_vec_region: assert property (MEM_ADDR >= 20'h0_FFDC && MEM_ADDR <= 20'h0_FFFF |->
    MEM_REGION == 3'h7) else $error("vector area not decoded");
  a_ram_region: assert property (MEM_ADDR >= 20'h0_0400 && MEM_ADDR < 20'h0_0400 + RAM_BYTES |->
    MEM_REGION == 3'h3) else $error("RAM area not decoded");
  a_sfr_region: assert property (MEM_ADDR <= 20'h0_02FF |-> MEM_REGION == 3'h1)
    else $error("control area not decoded");
endmodule : cpurf_top_asserts
bind cpurf_top cpurf_top_asserts #(.RAM_BYTES(RAM_BYTES)) i_chk (.CORE_CLK(CORE_CLK), .SRST(SRST),
  .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IP_LOAD(IP_LOAD),
  .IP_NEXT(IP_NEXT), .FLAG_EN(FLAG_EN), .FLAG_SIZE(FLAG_SIZE), .ALU_RESULT(ALU_RESULT),
  .ALU_CARRY(ALU_CARRY), .ALU_OVF(ALU_OVF), .DATA_WORD_ZERO(DATA_WORD_ZERO),
  .DATA_WORD_TWO(DATA_WORD_TWO), .DATA_ZERO_HIGH_BYTE(DATA_ZERO_HIGH_BYTE),
  .DATA_ZERO_LOW_BYTE(DATA_ZERO_LOW_BYTE), .LONG_DATA_PAIR_LOW(LONG_DATA_PAIR_LOW),
  .INSTRUCTION_POINTER(INSTRUCTION_POINTER), .ACTIVE_STACK_POINTER(ACTIVE_STACK_POINTER),
  .CPU_STATE_WORD(CPU_STATE_WORD), .MEM_ADDR(MEM_ADDR), .MEM_REGION(MEM_REGION));
`default_nettype wire

/* verif/cpu_regfile_and_addr_map_bench.sv */
// Self-checking bench for the register set and address decoder
`default_nettype none
module cpu_regfile_and_addr_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, bs, wbe, wbh, fle, cy, ov, ipl;
  logic [3:0] addr = '0, wbi;
  logic [19:0] wdata = '0, maddr = '0, rdata, ipn, ip;
  logic [1:0] wbs, fls;
  logic [31:0] lpl, lph, lpp, wbd, res;
  logic [15:0] asp;
  logic [10:0] st;
  logic [2:0] rg;
  logic mres;
  int miscompares = 0, cmp_count = 0;
  // Flag cases {size, result, carry, ovf, expected O S Z C}
  logic [39:0] ft [6] = '{{2'h0, 32'h0000_0100, 2'b10, 4'b0011}, {2'h1, 32'h0000_8000, 2'b01, 4'b1100},
    {2'h2, 32'h0000_0000, 2'b11, 4'b1011}, {2'h3, 32'hFFFF_FFFF, 2'b00, 4'b0100},
    {2'h0, 32'h0000_0080, 2'b00, 4'b0100}, {2'h1, 32'h0001_0000, 2'b00, 4'b0010}};
  // Region edges {address, region}
  logic [22:0] dt [14] = '{{20'h0_0000, 3'h1}, {20'h0_02FF, 3'h1}, {20'h0_0300, 3'h0},
    {20'h0_0400, 3'h3}, {20'h0_07FF, 3'h3}, {20'h0_0800, 3'h0}, {20'h0_2400, 3'h2},
    {20'h0_2BFF, 3'h2}, {20'h0_2C00, 3'h0}, {20'h0_BFFF, 3'h0}, {20'h0_C000, 3'h6},
    {20'h0_FFDB, 3'h6}, {20'h0_FFDC, 3'h7}, {20'hF_FFFF, 3'h0}};
  // Lowest control-area byte marked unused so the reserved flag can be seen
  cpurf_top #(.SFR_USED({{767{1'b1}}, 1'b0})) i_dut (.CORE_CLK(clk), .SRST(srst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .WB_EN(wbe), .WB_IDX(wbi), .WB_SIZE(wbs), .WB_HIGH(wbh),
    .WB_DATA(wbd), .FLAG_EN(fle), .FLAG_SIZE(fls), .ALU_RESULT(res), .ALU_CARRY(cy), .ALU_OVF(ov),
    .IP_LOAD(ipl), .IP_NEXT(ipn), .DATA_WORD_ZERO(), .DATA_WORD_ONE(), .DATA_WORD_TWO(),
    .DATA_WORD_THREE(), .DATA_ZERO_HIGH_BYTE(), .DATA_ZERO_LOW_BYTE(), .LONG_DATA_PAIR_LOW(lpl),
    .LONG_DATA_PAIR_HIGH(lph), .LONG_POINTER_PAIR(lpp), .FRAME_POINTER(), .STATIC_BASE_POINTER(),
    .VECTOR_TABLE_BASE(), .INSTRUCTION_POINTER(ip), .ACTIVE_STACK_POINTER(asp),
    .CPU_STATE_WORD(st), .BANK_SEL(bs), .MEM_ADDR(maddr), .MEM_REGION(rg), .MEM_RESERVED(mres));
  cpurf_core_model i_core (.clk(clk), .wb_en(wbe), .wb_idx(wbi), .wb_size(wbs), .wb_high(wbh),
    .wb_data(wbd), .fl_en(fle), .fl_size(fls), .res(res), .cy(cy), .ov(ov), .ip_ld(ipl),
    .ip_nx(ipn));
  initial forever #5 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [19:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  // Data is valid from the cycle after the strobe and holds while the address holds
  task automatic reg_rd(input logic [3:0] a, output logic [19:0] d);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Watchdog well above the roughly 150 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    logic [19:0] d;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      reg_rd(4'(i), d);
      chk("reset", d, 0);
    end
    // All ones written; readback trimmed to width, debug bit and holes stay 0
    for (int i = 0; i < 16; i++) if (i != 13) begin
      reg_wr(4'(i), 20'hF_FFFF);
      reg_rd(4'(i), d);
      chk("width", d, (i == 7 || i == 8) ? 20'hF_FFFF : i == 12 ? 20'h0_07FD : i > 12 ? 0 : 20'h0_FFFF);
    end
    $display("register widths done");
    reg_wr(4'h9, 20'h0_1234);
    reg_wr(4'hA, 20'h0_ABCD);
    reg_rd(4'hD, d);
    chk("stack handler", d, 20'h0_ABCD);
    reg_wr(4'hC, 20'h0_0010);
    #1 chk("stack task", asp, 16'h1234);
    chk("bank", bs, 1'b1);
    i_core.wb(4'h0, 2'h2, 1'b0, 32'h89AB_CDEF);
    i_core.wb(4'h0, 2'h0, 1'b1, 32'h0000_005A);
    #1 chk("low pair", lpl, 32'h89AB_5AEF);
    i_core.wb(4'h1, 2'h2, 1'b0, 32'h0123_4567);
    i_core.wb(4'h4, 2'h2, 1'b0, 32'hFEDC_BA98);
    #1 chk("high pair", lph, 32'h0123_4567);
    chk("pointer pair", lpp, 32'hFEDC_BA98);
    $display("stacks and pairs done");
    foreach (ft[k]) begin
      i_core.alu(ft[k][39:38], ft[k][37:6], ft[k][5], ft[k][4]);
      #1 chk("flags", {st[5], st[3:0]}, {ft[k][3:1], 1'b0, ft[k][0]});
    end
    i_core.jump(20'hF_FFFF);
    #1 chk("ip", ip, 20'hF_FFFF);
    $display("core updates done");
    foreach (dt[k]) begin
      @(posedge clk);
      maddr <= dt[k][22:3];
      #1 chk("region", rg, dt[k][2:0]);
      chk("reserved", mres, k == 0);
    end
    $display("decode done");
    results();
  end
endmodule : cpu_regfile_and_addr_map_bench
`default_nettype wire
